//--- bench/par_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none
module par_regs_bench;
	// ---------------------------------------------------------------
	// stimulus and observed signals
	// ---------------------------------------------------------------
	logic        core_clk = 1'b0;
	logic        sys_rst  = 1'b1;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [7:0]  paddr    = 8'h00;
	logic [31:0] pwdata   = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ext_pin  = 1'b0;
	logic        lc_out   = 1'b0;
	logic        osc;
	logic        carry;
	logic        flag;
	int          failures = 0;
	int          n_checks = 0;
	int          tcnt     = 0;
	int          n;

	always #5 core_clk = ~core_clk;

	// periodic sources: pin rises every 6 cycles, logic cell every 4
	always @(posedge core_clk) begin
		tcnt <= tcnt + 1;
		if (tcnt % 3 == 2) ext_pin <= ~ext_pin;
		if (tcnt % 2 == 1) lc_out <= ~lc_out;
	end

	par_regs u_par_regs (
		.core_clk_in                      (core_clk),
		.sys_rst_in                       (sys_rst),
		.psel_in                          (psel),
		.penable_in                       (penable),
		.pwrite_in                        (pwrite),
		.paddr_in                         (paddr),
		.pwdata_in                        (pwdata),
		.prdata_out                       (prdata),
		.pready_out                       (pready),
		.pslverr_out                      (pslverr),
		.external_oscillator_clock_pin_in (ext_pin),
		.logic_cell_one_output_in         (lc_out),
		.oscillator_out                   (osc),
		.accumulator_carry_event_out      (carry),
		.oscillator_interrupt_flag_out    (flag)
	);

	// ---------------------------------------------------------------
	// reporting
	// ---------------------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d, errors %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic timeout();
		failures++;
		$display("Error at %0t: wait ran out", $time);
		tally_and_finish();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_rng(input int got, input int lo, input int hi, input string what);
		n_checks++;
		if (got < lo || got > hi) begin
			failures++;
			$display("Error at %0t: %s got %0d expected %0d..%0d", $time, what, got, lo, hi);
		end
	endtask

	// ---------------------------------------------------------------
	// apb master: setup, then access held until pready
	// ---------------------------------------------------------------
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		int i;
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge core_clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) timeout();
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		xfer(1'b1, a, {24'h00_0000, d}, r, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic exp_err);
		logic [31:0] r;
		logic        e;
		xfer(1'b0, a, 32'h0000_0000, r, e);
		chk(r, {24'h00_0000, exp}, "read data");
		chk(32'(e), 32'(exp_err), "slave error");
	endtask

	// ---------------------------------------------------------------
	// oscillator observation
	// ---------------------------------------------------------------
	task automatic gap(output int k);
		int i;
		i = 0;
		while (carry !== 1'b1 && i < 3000) begin
			@(posedge core_clk);
			i++;
		end
		if (carry !== 1'b1) timeout();
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (carry !== 1'b1 && k < 3000);
		if (carry !== 1'b1) timeout();
	endtask

	task automatic hi_len(output int k);
		int i;
		i = 0;
		while (osc !== 1'b0 && i < 3000) begin
			@(posedge core_clk);
			i++;
		end
		while (osc !== 1'b1 && i < 3000) begin
			@(posedge core_clk);
			i++;
		end
		if (osc !== 1'b1) timeout();
		k = 0;
		while (osc === 1'b1 && k < 3000) begin
			@(posedge core_clk);
			k++;
		end
		if (osc === 1'b1) timeout();
	endtask

	task automatic run(input logic [1:0] cks, input logic [2:0] pws, input logic pfm);
		wr(par_pkg::CLOCK_ADDR, {pws, 3'h0, cks});
		wr(par_pkg::CONTROL_ADDR, {1'b1, 6'h00, pfm});
	endtask

	task automatic check_reset();
		rd(par_pkg::ACC_LOW_ADDR, 8'h00, 1'b0);
		rd(par_pkg::ACC_HIGH_ADDR, 8'h00, 1'b0);
		rd(par_pkg::ACC_UPPER_ADDR, 8'h00, 1'b0);
		rd(par_pkg::INC_LOW_ADDR, 8'h01, 1'b0);
		rd(par_pkg::INC_HIGH_ADDR, 8'h00, 1'b0);
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	// expected carry gaps for increment 0x8000 (32 ticks per wrap)
	int lo_tab [4] = '{198, 32, 128, 192};
	int hi_tab [4] = '{202, 32, 128, 192};

	initial begin
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		check_reset();
		wr(par_pkg::ACC_LOW_ADDR, 8'ha5);
		wr(par_pkg::ACC_HIGH_ADDR, 8'h5a);
		wr(par_pkg::ACC_UPPER_ADDR, 8'hff);
		rd(par_pkg::ACC_LOW_ADDR, 8'ha5, 1'b0);
		rd(par_pkg::ACC_HIGH_ADDR, 8'h5a, 1'b0);
		rd(par_pkg::ACC_UPPER_ADDR, 8'h0f, 1'b0);
		rd(8'h20, 8'h00, 1'b1);
		rd(8'h01, 8'h00, 1'b1);
		wr(par_pkg::INC_HIGH_ADDR, 8'h80);
		rd(par_pkg::INC_HIGH_ADDR, 8'h80, 1'b0);
		wr(par_pkg::INC_LOW_ADDR, 8'h00);
		rd(par_pkg::INC_LOW_ADDR, 8'h00, 1'b0);
		wr(par_pkg::ACC_UPPER_ADDR, 8'h00);
		wr(par_pkg::ACC_HIGH_ADDR, 8'h00);
		wr(par_pkg::ACC_LOW_ADDR, 8'h00);
		run(2'h1, 3'h0, 1'b0);
		gap(n);
		gap(n);
		chk_rng(n, 32, 32, "carry gap");
		chk(32'(flag), 32'h0000_0001, "flag");
		hi_len(n);
		chk_rng(n, 32, 32, "duty high");
		// high byte alone must not reach the adder
		wr(par_pkg::INC_HIGH_ADDR, 8'h40);
		gap(n);
		gap(n);
		chk_rng(n, 32, 32, "gap after high write");
		wr(par_pkg::INC_LOW_ADDR, 8'h00);
		gap(n);
		gap(n);
		chk_rng(n, 64, 64, "gap after low write");
		wr(par_pkg::INC_HIGH_ADDR, 8'h80);
		wr(par_pkg::INC_LOW_ADDR, 8'h00);
		for (int p = 0; p < 5; p++) begin
			run(2'h1, 3'(p), 1'b1);
			rd(par_pkg::CLOCK_ADDR, {3'(p), 5'h01}, 1'b0);
			hi_len(n);
			hi_len(n);
			chk_rng(n, 1 << p, 1 << p, "pulse width");
		end
		for (int c = 0; c < 4; c++) begin
			run(2'(c), 3'h0, 1'b0);
			gap(n);
			gap(n);
			chk_rng(n, lo_tab[c], hi_tab[c], "source gap");
		end
		wr(par_pkg::CONTROL_ADDR, 8'h00);
		repeat (4) @(posedge core_clk);
		chk(32'(osc), 32'h0000_0000, "output while off");
		chk(32'(flag), 32'h0000_0001, "flag held");
		rd(par_pkg::CONTROL_ADDR, 8'h00, 1'b0);
		rd(par_pkg::CLOCK_ADDR, 8'h03, 1'b0);
		wr(par_pkg::STATUS_ADDR, 8'h01);
		@(posedge core_clk);
		chk(32'(flag), 32'h0000_0000, "flag cleared");
		wr(par_pkg::ACC_LOW_ADDR, 8'h33);
		sys_rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		check_reset();
		tally_and_finish();
	end
endmodule
`default_nettype wire

//--- logic/par_clk_sel.sv
`timescale 1ns/10ps
`default_nettype none
module par_clk_sel (
	// clock and reset
	input  wire logic core_clk_in,
	input  wire logic sys_rst_in,
	// asynchronous sources
	input  wire logic external_oscillator_clock_pin_in,
	input  wire logic logic_cell_one_output_in,
	// tick to the accumulator
	par_tick_if.src   tk
);
	typedef struct packed {
		logic       pin_s1;
		logic       pin_s2;
		logic       pin_d;
		logic       lc_s1;
		logic       lc_s2;
		logic       lc_d;
		logic [6:0] frac;
		logic       tick;
	} par_sel_s;

	par_sel_s sel_reg;
	par_sel_s sel_next;

	// ---------------------------------------------------------------
	// source select and rate enable
	// ---------------------------------------------------------------
	// 16 MHz from 100 MHz by fractional stepping: pulses are not evenly spaced
	always_comb begin
		sel_next        = sel_reg;
		sel_next.pin_s1 = external_oscillator_clock_pin_in;
		sel_next.pin_s2 = sel_reg.pin_s1;
		sel_next.pin_d  = sel_reg.pin_s2;
		sel_next.lc_s1  = logic_cell_one_output_in;
		sel_next.lc_s2  = sel_reg.lc_s1;
		sel_next.lc_d   = sel_reg.lc_s2;
		if (sel_reg.frac + 7'(par_pkg::HFOSC_MHZ) >= 7'(par_pkg::CORE_MHZ)) begin
			sel_next.frac = sel_reg.frac + 7'(par_pkg::HFOSC_MHZ) - 7'(par_pkg::CORE_MHZ);
		end else begin
			sel_next.frac = sel_reg.frac + 7'(par_pkg::HFOSC_MHZ);
		end
		case (tk.oscillator_clock_select)
			par_pkg::CKS_PIN:   sel_next.tick = sel_reg.pin_s2 & ~sel_reg.pin_d;
			par_pkg::CKS_LC1:   sel_next.tick = sel_reg.lc_s2 & ~sel_reg.lc_d;
			par_pkg::CKS_SYS:   sel_next.tick = 1'b1;
			par_pkg::CKS_HFOSC: sel_next.tick =
				(sel_reg.frac + 7'(par_pkg::HFOSC_MHZ) >= 7'(par_pkg::CORE_MHZ));
			default:            sel_next.tick = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sel_reg <= '0;
		end else begin
			sel_reg <= sel_next;
		end
	end

	assign tk.tick = sel_reg.tick;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_sys_clk_tick: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		tk.oscillator_clock_select == par_pkg::CKS_SYS [*2] |-> tk.tick)
		else $error("system clock source does not tick every cycle");

	a_pin_edge_tick: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		tk.oscillator_clock_select == par_pkg::CKS_PIN && $rose(sel_reg.pin_s2)
		|=> tk.tick)
		else $error("pin rising edge gave no tick");

endmodule
`default_nettype wire

//--- logic/par_pkg.sv
`default_nettype none
package par_pkg;

	// ---------------------------------------------------------------
	// register byte addresses
	// ---------------------------------------------------------------
	localparam logic [7:0] ACC_LOW_ADDR   = 8'h00;
	localparam logic [7:0] ACC_HIGH_ADDR  = 8'h04;
	localparam logic [7:0] ACC_UPPER_ADDR = 8'h08;
	localparam logic [7:0] INC_LOW_ADDR   = 8'h0c;
	localparam logic [7:0] INC_HIGH_ADDR  = 8'h10;
	localparam logic [7:0] CONTROL_ADDR   = 8'h14;
	localparam logic [7:0] CLOCK_ADDR     = 8'h18;
	localparam logic [7:0] STATUS_ADDR    = 8'h1c;

	// ---------------------------------------------------------------
	// widths and field positions
	// ---------------------------------------------------------------
	localparam int ACC_W        = 20;
	localparam int INC_W        = 16;
	localparam int CTL_EN_BIT   = 7;
	localparam int CTL_OUT_BIT  = 5;
	localparam int CTL_PFM_BIT  = 0;
	localparam int CLK_PWS_LSB  = 5;
	localparam int CLK_CKS_LSB  = 0;
	localparam int STS_FLAG_BIT = 0;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [19:0] ACC_RST     = 20'h0_0000;
	localparam logic [15:0] INC_RST     = 16'h0001;
	localparam logic [7:0]  INC_BUF_RST = 8'h00;

	// ---------------------------------------------------------------
	// clock source codes
	// ---------------------------------------------------------------
	localparam logic [1:0] CKS_HFOSC = 2'h0;
	localparam logic [1:0] CKS_SYS   = 2'h1;
	localparam logic [1:0] CKS_LC1   = 2'h2;
	localparam logic [1:0] CKS_PIN   = 2'h3;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CORE_MHZ  = 100;
	localparam int HFOSC_MHZ = 16;

endpackage
`default_nettype wire

//--- logic/par_regs.sv
// Overview of operation
// - accumulator bits 7..0 readable and writable as the low byte register
// - accumulator bits 15..8 readable and writable as the high byte register
// - accumulator bits 19..16 sit in bits 3..0 of the upper byte register
// - upper byte bits 7..4 read as zero and ignore writes
// - increment low byte is read/write and resets to 0x01
// - increment high byte is read/write and resets to zero
// - accumulator and increment high byte reset to zero on every reset
// - accumulator overflow sets the interrupt flag until software clears it
// - pulse frequency output pulse lasts 2**code oscillator clock periods
// - two-bit code selects pin, logic cell, system clock or 16 MHz source
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module par_regs (
	// clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        sys_rst_in,
	// apb slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output var  logic [31:0] prdata_out,
	output var  logic        pready_out,
	output var  logic        pslverr_out,
	// clock sources
	input  wire logic        external_oscillator_clock_pin_in,
	input  wire logic        logic_cell_one_output_in,
	// oscillator results
	output var  logic        oscillator_out,
	output var  logic        accumulator_carry_event_out,
	output var  logic        oscillator_interrupt_flag_out
);
	typedef struct packed {
		logic [19:0] acc;
		logic [15:0] inc;
		logic [7:0]  inc_buf;
		logic        en;
		logic        pfm;
		logic [2:0]  pws;
		logic [1:0]  cks;
		logic        flag;
		logic        out;
		logic [7:0]  pw_cnt;
		logic        carry;
		logic [31:0] prdata;
	} par_top_s;

	par_top_s   st_reg;
	par_top_s   st_next;
	par_tick_if tk ();

	logic        wr_access;
	logic        rd_setup;
	logic        addr_hit;
	logic [20:0] acc_sum;
	logic        acc_carry;
	logic [31:0] rd_value;

	par_clk_sel u_clk_sel (
		.core_clk_in                      (core_clk_in),
		.sys_rst_in                       (sys_rst_in),
		.external_oscillator_clock_pin_in (external_oscillator_clock_pin_in),
		.logic_cell_one_output_in         (logic_cell_one_output_in),
		.tk                               (tk.src)
	);

	assign tk.oscillator_clock_select = st_reg.cks;

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	assign wr_access = psel_in & penable_in & pwrite_in;
	assign rd_setup  = psel_in & ~penable_in & ~pwrite_in;
	assign addr_hit  = (paddr_in <= par_pkg::STATUS_ADDR) && (paddr_in[1:0] == 2'h0);

	always_comb begin
		rd_value = 32'h0000_0000;
		case (paddr_in)
			par_pkg::ACC_LOW_ADDR:   rd_value[7:0] = st_reg.acc[7:0];
			par_pkg::ACC_HIGH_ADDR:  rd_value[7:0] = st_reg.acc[15:8];
			par_pkg::ACC_UPPER_ADDR: rd_value[3:0] = st_reg.acc[19:16];
			par_pkg::INC_LOW_ADDR:   rd_value[7:0] = st_reg.inc[7:0];
			par_pkg::INC_HIGH_ADDR:  rd_value[7:0] = st_reg.inc_buf;
			par_pkg::CONTROL_ADDR: begin
				rd_value[par_pkg::CTL_EN_BIT]  = st_reg.en;
				rd_value[par_pkg::CTL_OUT_BIT] = st_reg.out;
				rd_value[par_pkg::CTL_PFM_BIT] = st_reg.pfm;
			end
			par_pkg::CLOCK_ADDR: begin
				rd_value[par_pkg::CLK_PWS_LSB +: 3] = st_reg.pws;
				rd_value[par_pkg::CLK_CKS_LSB +: 2] = st_reg.cks;
			end
			par_pkg::STATUS_ADDR:    rd_value[par_pkg::STS_FLAG_BIT] = st_reg.flag;
			default:                 rd_value = 32'h0000_0000;
		endcase
	end

	// ---------------------------------------------------------------
	// accumulator
	// ---------------------------------------------------------------
	assign acc_sum   = {1'b0, st_reg.acc} + {5'h00, st_reg.inc};
	assign acc_carry = tk.tick & st_reg.en & acc_sum[20];

	always_comb begin
		st_next       = st_reg;
		st_next.carry = acc_carry;
		if (tk.tick && st_reg.en) begin
			st_next.acc = acc_sum[19:0];
		end
		// output stage
		if (!st_reg.en) begin
			st_next.out    = 1'b0;
			st_next.pw_cnt = 8'h00;
		end else if (acc_carry) begin
			if (st_reg.pfm) begin
				st_next.out    = 1'b1;
				st_next.pw_cnt = (8'h01 << st_reg.pws) - 8'h01;
			end else begin
				st_next.out = ~st_reg.out;
			end
		end else if (tk.tick && st_reg.pfm && st_reg.out) begin
			if (st_reg.pw_cnt == 8'h00) begin
				st_next.out = 1'b0;
			end else begin
				st_next.pw_cnt = st_reg.pw_cnt - 8'h01;
			end
		end
		// software writes land after accumulation so the written byte wins
		if (wr_access) begin
			case (paddr_in)
				par_pkg::ACC_LOW_ADDR:   st_next.acc[7:0]   = pwdata_in[7:0];
				par_pkg::ACC_HIGH_ADDR:  st_next.acc[15:8]  = pwdata_in[7:0];
				par_pkg::ACC_UPPER_ADDR: st_next.acc[19:16] = pwdata_in[3:0];
				par_pkg::INC_LOW_ADDR:   st_next.inc = {st_reg.inc_buf, pwdata_in[7:0]};
				par_pkg::INC_HIGH_ADDR:  st_next.inc_buf = pwdata_in[7:0];
				par_pkg::CONTROL_ADDR: begin
					st_next.en  = pwdata_in[par_pkg::CTL_EN_BIT];
					st_next.pfm = pwdata_in[par_pkg::CTL_PFM_BIT];
				end
				par_pkg::CLOCK_ADDR: begin
					st_next.pws = pwdata_in[par_pkg::CLK_PWS_LSB +: 3];
					st_next.cks = pwdata_in[par_pkg::CLK_CKS_LSB +: 2];
				end
				par_pkg::STATUS_ADDR: begin
					if (pwdata_in[par_pkg::STS_FLAG_BIT]) begin
						st_next.flag = 1'b0;
					end
				end
				default: st_next.flag = st_next.flag;
			endcase
		end
		// a carry in the clearing cycle still leaves the flag set
		if (acc_carry) begin
			st_next.flag = 1'b1;
		end
		if (rd_setup) begin
			st_next.prdata = addr_hit ? rd_value : 32'h0000_0000;
		end
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_reg         <= '0;
			st_reg.acc     <= par_pkg::ACC_RST;
			st_reg.inc     <= par_pkg::INC_RST;
			st_reg.inc_buf <= par_pkg::INC_BUF_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign prdata_out                    = st_reg.prdata;
	assign pready_out                    = 1'b1;
	assign pslverr_out                   = psel_in & penable_in & ~addr_hit;
	assign oscillator_out                = st_reg.out;
	assign accumulator_carry_event_out   = st_reg.carry;
	assign oscillator_interrupt_flag_out = st_reg.flag;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);

	a_acc_low_write: assert property (
		wr_access && paddr_in == par_pkg::ACC_LOW_ADDR
		|=> st_reg.acc[7:0] == $past(pwdata_in[7:0]))
		else $error("accumulator low byte write lost");

	a_acc_high_write: assert property (
		wr_access && paddr_in == par_pkg::ACC_HIGH_ADDR
		|=> st_reg.acc[15:8] == $past(pwdata_in[7:0]))
		else $error("accumulator high byte write lost");

	a_acc_upper_write: assert property (
		wr_access && paddr_in == par_pkg::ACC_UPPER_ADDR
		|=> st_reg.acc[19:16] == $past(pwdata_in[3:0]))
		else $error("accumulator upper nibble write lost");

	a_upper_read_zero: assert property (
		rd_setup && paddr_in == par_pkg::ACC_UPPER_ADDR
		|=> prdata_out[31:4] == 28'h000_0000 && prdata_out[3:0] == $past(st_reg.acc[19:16]))
		else $error("upper byte read shows unimplemented bits");

	a_reset_values: assert property (
		$fell(sys_rst_in) |-> st_reg.inc == 16'h0001 && st_reg.inc_buf == 8'h00
		&& st_reg.acc == 20'h0_0000)
		else $error("reset values wrong");

	a_inc_high_held: assert property (
		wr_access && paddr_in == par_pkg::INC_HIGH_ADDR
		|=> st_reg.inc == $past(st_reg.inc) && st_reg.inc_buf == $past(pwdata_in[7:0]))
		else $error("high byte write reached the adder early");

	a_inc_low_load: assert property (
		wr_access && paddr_in == par_pkg::INC_LOW_ADDR
		|=> st_reg.inc == {$past(st_reg.inc_buf), $past(pwdata_in[7:0])})
		else $error("low byte write did not load full increment");

	a_acc_step: assert property (
		tk.tick && st_reg.en && !wr_access
		|=> st_reg.acc == $past(acc_sum[19:0]) && st_reg.carry == $past(acc_sum[20]))
		else $error("accumulator step wrong");

	a_flag_on_carry: assert property (
		acc_carry |=> st_reg.flag [*2] or (st_reg.flag ##1 $past(wr_access)))
		else $error("carry did not set interrupt flag");

	a_fdc_toggle: assert property (
		acc_carry && !st_reg.pfm |=> st_reg.out != $past(st_reg.out))
		else $error("fixed duty output did not toggle");

	a_pfm_pulse_load: assert property (
		acc_carry && st_reg.pfm
		|=> st_reg.out && st_reg.pw_cnt == (8'h01 << $past(st_reg.pws)) - 8'h01)
		else $error("pulse width not loaded");

	// read-back: the byte shows in the access cycle after its setup
	a_acc_low_read: assert property (
		rd_setup && paddr_in == par_pkg::ACC_LOW_ADDR
		|=> prdata_out == {24'h00_0000, $past(st_reg.acc[7:0])})
		else $error("accumulator low byte read wrong");

	a_acc_high_read: assert property (
		rd_setup && paddr_in == par_pkg::ACC_HIGH_ADDR
		|=> prdata_out == {24'h00_0000, $past(st_reg.acc[15:8])})
		else $error("accumulator high byte read wrong");

	a_inc_low_read: assert property (
		rd_setup && paddr_in == par_pkg::INC_LOW_ADDR
		|=> prdata_out == {24'h00_0000, $past(st_reg.inc[7:0])})
		else $error("increment low byte read wrong");

	a_inc_high_read: assert property (
		rd_setup && paddr_in == par_pkg::INC_HIGH_ADDR
		|=> prdata_out == {24'h00_0000, $past(st_reg.inc_buf)})
		else $error("increment high byte read wrong");

	a_clock_read: assert property (
		rd_setup && paddr_in == par_pkg::CLOCK_ADDR
		|=> prdata_out == {24'h00_0000, $past(st_reg.pws), 3'h0, $past(st_reg.cks)})
		else $error("clock select read wrong");

	a_flag_clear: assert property (
		wr_access && paddr_in == par_pkg::STATUS_ADDR
		&& pwdata_in[par_pkg::STS_FLAG_BIT] && !acc_carry
		|=> !st_reg.flag)
		else $error("interrupt flag not cleared");

	a_flag_sticky: assert property (
		st_reg.flag && !(wr_access && paddr_in == par_pkg::STATUS_ADDR)
		|=> st_reg.flag)
		else $error("interrupt flag dropped without a clear");

	a_disabled_hold: assert property (
		!st_reg.en && !wr_access
		|=> st_reg.acc == $past(st_reg.acc) && !st_reg.out && !st_reg.carry)
		else $error("disabled oscillator still moved");

	a_pulse_count: assert property (
		st_reg.en && st_reg.pfm && st_reg.out && tk.tick && !acc_carry
		&& st_reg.pw_cnt != 8'h00
		|=> st_reg.out && st_reg.pw_cnt == $past(st_reg.pw_cnt) - 8'h01)
		else $error("pulse width count did not step");

	a_pulse_end: assert property (
		st_reg.en && st_reg.pfm && st_reg.out && tk.tick && !acc_carry
		&& st_reg.pw_cnt == 8'h00
		|=> !st_reg.out)
		else $error("pulse did not end");

	c_carry_seen:   cover property (acc_carry);
	c_pfm_pulse:    cover property (st_reg.pfm && acc_carry ##[1:300] $fell(st_reg.out));
	c_flag_cleared: cover property (st_reg.flag ##1 !st_reg.flag);
	c_inc_pair:     cover property (wr_access && paddr_in == par_pkg::INC_HIGH_ADDR
		##[1:20] wr_access && paddr_in == par_pkg::INC_LOW_ADDR);
	c_pin_carry:    cover property (st_reg.cks == par_pkg::CKS_PIN && acc_carry);

endmodule
`default_nettype wire

//--- logic/par_tick_if.sv
`timescale 1ns/10ps
`default_nettype none
interface par_tick_if;
	logic [1:0] oscillator_clock_select;
	logic       tick;
	modport src (input oscillator_clock_select, output tick);
	modport dst (output oscillator_clock_select, input tick);
endinterface
`default_nettype wire
